/* src/sdram_burst_data_path.sv */
// sdram_burst_data_path: read and write burst data path of the dram
// assumes: all pins (command clock, commands, strobe, data) are sampled
// by clk well above the command clock rate; mode bits set over the port
`default_nettype none

module sdram_burst_data_path #(
    parameter int DATA_W      = 8,
    parameter int QUEUE_DEPTH = 4
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // command pins, taken at the rising command clock edge; on_die_termination is followed every clk
    input  wire logic              ck,
    input  wire logic              cmd_activate,
    input  wire logic              cmd_read,
    input  wire logic              cmd_write,
    input  wire logic [2:0]        cmd_bank,
    input  wire logic [2:0]        cmd_column,
    input  wire logic              cmd_auto_precharge,
    input  wire logic              chop_select_address_bit,
    input  wire logic              on_die_termination,
    // data and strobe pins
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe_n,
    input  wire logic              write_mask_input,
    input  wire logic              data_strobe_in,
    output logic                   data_strobe_out,
    output logic                   data_strobe_c_out,
    output logic                   data_strobe_oe_n,
    output logic                   termination_on,
    output logic      [7:0]        bank_open
);
    localparam int SYNC_W = DATA_W + 15;
    localparam int SLOT_W = 17;

    // synchronised pins
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic              ck_prev_reg;
    logic              dqs_prev_reg;

    // mode registers
    logic [15:0] mode0_reg;
    logic [15:0] mode2_reg;
    logic [15:0] cas_lat_reg;
    logic [15:0] reg_rdata_reg;

    // command clock bookkeeping
    logic [7:0]  rise_cnt_reg;
    logic [7:0]  now;
    logic        ck_s;
    logic        ck_rise;
    logic        ck_edge;

    // synchronised pin views
    logic              s_act;
    logic              s_rd;
    logic              s_wr;
    logic [2:0]        s_bank;
    logic [2:0]        s_col;
    logic              s_ap;
    logic              s_chop;
    logic              s_odt;
    logic              s_mask;
    logic              dqs_s;
    logic [DATA_W-1:0] s_dq;
    logic              dqs_rise;
    logic              dqs_edge;

    // latencies
    logic [7:0] write_latency;
    logic [7:0] read_latency;
    logic       chop_now;

    // queue
    logic [SLOT_W-1:0] push_slot;
    logic [SLOT_W-1:0] head;
    logic              head_valid;
    logic              q_full;
    logic              head_due;
    logic              start_wr;
    logic              start_rd;

    // write burst
    logic              wr_armed_reg;
    logic              wr_active_reg;
    logic [2:0]        wr_beat_reg;
    logic [2:0]        wr_bank_reg;
    logic [2:0]        wr_col_reg;
    logic              wr_chop_reg;
    logic              wr_ap_reg;
    logic              cap_en;
    logic [2:0]        cur_bank;
    logic [2:0]        cur_col;
    logic              cur_chop;
    logic              cur_ap;

    // read burst
    sdram_burst_pkg::read_state_t rd_state_reg;
    logic [2:0]        rd_beat_reg;
    logic [2:0]        rd_bank_reg;
    logic [2:0]        rd_col_reg;
    logic              rd_chop_reg;

    // array and pin registers
    logic [DATA_W-1:0] mem_reg [64];
    logic [DATA_W-1:0] dq_out_reg;
    logic              dq_oe_n_reg;
    logic              dqs_out_reg;
    logic              dqs_c_out_reg;
    logic              dqs_oe_n_reg;
    logic              term_reg;
    logic [7:0]        bank_open_reg;

    function automatic logic [7:0] al_cycles(input logic [1:0] code, input logic [3:0] cl);
        case (code)
            sdram_burst_pkg::AL_CL_MINUS1: al_cycles = {4'h0, cl} - 8'h01;
            sdram_burst_pkg::AL_CL_MINUS2: al_cycles = {4'h0, cl} - 8'h02;
            default:                       al_cycles = 8'h00;
        endcase
    endfunction : al_cycles

    // sequential burst order within an aligned group of eight
    function automatic logic [5:0] mem_index(input logic [2:0] bank, input logic [2:0] col,
                                             input logic [2:0] beat);
        mem_index = {bank, col + beat};
    endfunction : mem_index

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            ck_prev_reg  <= 1'b0;
            dqs_prev_reg <= 1'b0;
        end else begin
            sync1_reg    <= {ck, cmd_activate, cmd_read, cmd_write, cmd_bank, cmd_column,
                             cmd_auto_precharge, chop_select_address_bit, on_die_termination,
                             write_mask_input, data_strobe_in, dq_in};
            sync2_reg    <= sync1_reg;
            ck_prev_reg  <= ck_s;
            dqs_prev_reg <= dqs_s;
        end
    end

    assign {ck_s, s_act, s_rd, s_wr, s_bank, s_col, s_ap, s_chop, s_odt, s_mask, dqs_s,
            s_dq} = sync2_reg;
    assign ck_rise  = ck_s && !ck_prev_reg;
    assign ck_edge  = ck_s != ck_prev_reg;
    assign dqs_rise = dqs_s && !dqs_prev_reg;
    assign dqs_edge = dqs_s != dqs_prev_reg;
    assign now      = rise_cnt_reg + 8'h01;

    // mode registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode0_reg   <= sdram_burst_pkg::MODE0_RESET;
            mode2_reg   <= sdram_burst_pkg::MODE2_RESET;
            cas_lat_reg <= sdram_burst_pkg::CAS_LAT_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                sdram_burst_pkg::ADDR_MODE0:   mode0_reg   <= reg_wdata;
                sdram_burst_pkg::ADDR_MODE2:   mode2_reg   <= reg_wdata;
                sdram_burst_pkg::ADDR_CAS_LAT: cas_lat_reg <= reg_wdata;
                default:                       mode0_reg   <= mode0_reg;
            endcase
        end
    end

    // register read, data the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata_reg <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                sdram_burst_pkg::ADDR_MODE0:   reg_rdata_reg <= mode0_reg;
                sdram_burst_pkg::ADDR_MODE2:   reg_rdata_reg <= mode2_reg;
                sdram_burst_pkg::ADDR_CAS_LAT: reg_rdata_reg <= cas_lat_reg;
                sdram_burst_pkg::ADDR_STATUS: begin
                    reg_rdata_reg <= '0;
                    reg_rdata_reg[sdram_burst_pkg::ST_OPEN_LSB +: 8] <= bank_open_reg;
                    reg_rdata_reg[sdram_burst_pkg::ST_WR_BIT]   <= wr_armed_reg;
                    reg_rdata_reg[sdram_burst_pkg::ST_RD_BIT]   <=
                        rd_state_reg != sdram_burst_pkg::RD_IDLE;
                    reg_rdata_reg[sdram_burst_pkg::ST_FULL_BIT] <= q_full;
                end
                default:                       reg_rdata_reg <= '0;
            endcase
        end
    end

    // write latency from all three mode registers
    assign write_latency = al_cycles(mode0_reg[sdram_burst_pkg::MODE0_AL_LSB +: 2],
                                     cas_lat_reg[3:0])
                         + {4'h0, mode2_reg[sdram_burst_pkg::LAT_LSB +: 4]};
    assign read_latency  = al_cycles(mode0_reg[sdram_burst_pkg::MODE0_AL_LSB +: 2],
                                     cas_lat_reg[3:0])
                         + {4'h0, cas_lat_reg[sdram_burst_pkg::LAT_LSB +: 4]};

    // burst length per command
    always_comb begin
        case (mode0_reg[sdram_burst_pkg::MODE0_BL_LSB +: 2])
            sdram_burst_pkg::BURST_FIXED8: chop_now = 1'b0;
            sdram_burst_pkg::BURST_OTF:    chop_now = !s_chop;
            sdram_burst_pkg::BURST_FIXED4: chop_now = 1'b1;
            default:                       chop_now = 1'b0;
        endcase
    end

    // slot: write, chop, auto precharge, bank, column, due rise count
    always_comb begin
        push_slot = {s_wr, chop_now, s_ap, s_bank, s_col, now + read_latency - 8'h01};
        if (s_wr) begin
            push_slot[7:0] = now + write_latency;
        end
    end

    assign head_due = head_valid && ck_rise && (head[7:0] == now);
    assign start_wr = head_due && head[16];
    assign start_rd = head_due && !head[16];

    burst_slot_queue #(
        .WIDTH (SLOT_W),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clk        (clk),
        .resetn     (resetn),
        .push       (ck_rise && (s_rd ^ s_wr)),
        .push_data  (push_slot),
        .pop        (head_due),
        .head       (head),
        .head_valid (head_valid),
        .full       (q_full)
    );

    // command clock rise counter
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rise_cnt_reg <= '0;
        end else if (ck_rise) begin
            rise_cnt_reg <= now;
        end
    end

    // write burst in force, live slot fields used on the starting cycle
    assign cur_bank = (start_wr && !wr_active_reg) ? head[13:11] : wr_bank_reg;
    assign cur_col  = (start_wr && !wr_active_reg) ? head[10:8]  : wr_col_reg;
    assign cur_chop = (start_wr && !wr_active_reg) ? head[15]    : wr_chop_reg;
    assign cur_ap   = (start_wr && !wr_active_reg) ? head[14]    : wr_ap_reg;
    assign cap_en   = (dqs_edge && wr_active_reg)
                   || (dqs_rise && (wr_armed_reg || start_wr) && !wr_active_reg);

    // write burst sequencing
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_armed_reg  <= 1'b0;
            wr_active_reg <= 1'b0;
            wr_beat_reg   <= '0;
            wr_bank_reg   <= '0;
            wr_col_reg    <= '0;
            wr_chop_reg   <= 1'b0;
            wr_ap_reg     <= 1'b0;
        end else begin
            if (start_wr) begin
                wr_armed_reg <= 1'b1;
                wr_bank_reg  <= head[13:11];
                wr_col_reg   <= head[10:8];
                wr_chop_reg  <= head[15];
                wr_ap_reg    <= head[14];
                wr_beat_reg  <= '0;
            end
            if (cap_en) begin
                // full slot of edges is consumed even when chopped
                if (wr_beat_reg == sdram_burst_pkg::LAST_BEAT8) begin
                    wr_active_reg <= 1'b0;
                    wr_armed_reg  <= start_wr; // new burst start wins
                    wr_beat_reg   <= '0;
                end else begin
                    wr_active_reg <= 1'b1;
                    wr_beat_reg   <= wr_beat_reg + 3'h1;
                end
            end
        end
    end

    // array write with masking and chop
    always_ff @(posedge clk) begin
        if (cap_en && !s_mask
                && (!cur_chop || wr_beat_reg <= sdram_burst_pkg::LAST_BEAT4)) begin
            mem_reg[mem_index(cur_bank, cur_col, wr_beat_reg)] <= s_dq;
        end
    end

    // open rows, auto precharge at write burst end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bank_open_reg <= '0;
        end else begin
            if (cap_en && cur_ap && wr_beat_reg == sdram_burst_pkg::LAST_BEAT8) begin
                bank_open_reg[cur_bank] <= 1'b0;
            end
            // activate wins over a same-cycle auto precharge
            if (ck_rise && s_act) begin
                bank_open_reg[s_bank] <= 1'b1;
            end
        end
    end

    // read burst strobe and data
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_state_reg  <= sdram_burst_pkg::RD_IDLE;
            rd_beat_reg   <= '0;
            rd_bank_reg   <= '0;
            rd_col_reg    <= '0;
            rd_chop_reg   <= 1'b0;
            dq_out_reg    <= '0;
            dq_oe_n_reg   <= 1'b1;
            dqs_out_reg   <= 1'b0;
            dqs_c_out_reg <= 1'b1;
            dqs_oe_n_reg  <= 1'b1;
        end else begin
            case (rd_state_reg)
                sdram_burst_pkg::RD_IDLE: begin
                    dq_oe_n_reg  <= 1'b1;
                    dqs_oe_n_reg <= 1'b1;
                    if (start_rd) begin
                        rd_state_reg  <= sdram_burst_pkg::RD_PREAMBLE;
                        rd_bank_reg   <= head[13:11];
                        rd_col_reg    <= head[10:8];
                        rd_chop_reg   <= head[15];
                        dqs_oe_n_reg  <= 1'b0;
                        dqs_out_reg   <= 1'b0;
                        dqs_c_out_reg <= 1'b1;
                    end
                end
                sdram_burst_pkg::RD_PREAMBLE: begin
                    if (ck_rise) begin
                        rd_state_reg  <= sdram_burst_pkg::RD_DATA;
                        rd_beat_reg   <= '0;
                        dq_oe_n_reg   <= 1'b0;
                        dq_out_reg    <= mem_reg[mem_index(rd_bank_reg, rd_col_reg, 3'h0)];
                        dqs_out_reg   <= 1'b1;
                        dqs_c_out_reg <= 1'b0;
                    end
                end
                sdram_burst_pkg::RD_DATA: begin
                    if (ck_edge) begin
                        // last beat is odd, so strobe already low for the postamble
                        if (rd_beat_reg == (rd_chop_reg ? sdram_burst_pkg::LAST_BEAT4
                                                        : sdram_burst_pkg::LAST_BEAT8)) begin
                            rd_state_reg <= sdram_burst_pkg::RD_IDLE;
                            dq_oe_n_reg  <= 1'b1;
                            dqs_oe_n_reg <= 1'b1;
                        end else begin
                            rd_beat_reg   <= rd_beat_reg + 3'h1;
                            dq_out_reg    <= mem_reg[mem_index(rd_bank_reg, rd_col_reg,
                                                               rd_beat_reg + 3'h1)];
                            dqs_out_reg   <= !dqs_out_reg;
                            dqs_c_out_reg <= dqs_out_reg;
                        end
                    end
                end
                default: begin
                    rd_state_reg <= sdram_burst_pkg::RD_IDLE;
                    dq_oe_n_reg  <= 1'b1;
                    dqs_oe_n_reg <= 1'b1;
                end
            endcase
        end
    end

    // termination only outside RD_DATA, one clk behind the data line enable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            term_reg <= 1'b0;
        end else begin
            term_reg <= s_odt && rd_state_reg != sdram_burst_pkg::RD_DATA;
        end
    end

    assign reg_rdata         = reg_rdata_reg;
    assign dq_out            = dq_out_reg;
    assign dq_oe_n           = dq_oe_n_reg;
    assign data_strobe_out   = dqs_out_reg;
    assign data_strobe_c_out = dqs_c_out_reg;
    assign data_strobe_oe_n  = dqs_oe_n_reg;
    assign termination_on    = term_reg;
    assign bank_open         = bank_open_reg;

endmodule : sdram_burst_data_path

`default_nettype wire

/* include/sdram_burst_pkg.sv */
// package: constants for the burst data path of the dram model
// assumes: users reference every item as sdram_burst_pkg::name
`default_nettype none

package sdram_burst_pkg;

    // register port
    localparam int          REG_AW        = 4;
    localparam int          REG_DW        = 16;
    localparam logic [3:0]  ADDR_MODE0    = 4'h0;
    localparam logic [3:0]  ADDR_MODE2    = 4'h1;
    localparam logic [3:0]  ADDR_CAS_LAT  = 4'h2;
    localparam logic [3:0]  ADDR_STATUS   = 4'h3;

    // field positions
    localparam int          MODE0_BL_LSB  = 0;
    localparam int          MODE0_AL_LSB  = 3;
    localparam int          LAT_LSB       = 0;
    localparam int          ST_OPEN_LSB   = 0;
    localparam int          ST_WR_BIT     = 8;
    localparam int          ST_RD_BIT     = 9;
    localparam int          ST_FULL_BIT   = 10;

    // reset values
    localparam logic [15:0] MODE0_RESET   = 16'h0000;
    localparam logic [15:0] MODE2_RESET   = 16'h0005;
    localparam logic [15:0] CAS_LAT_RESET = 16'h0005;

    // burst length field of mode register zero
    localparam logic [1:0]  BURST_FIXED8  = 2'h0;
    localparam logic [1:0]  BURST_OTF     = 2'h1;
    localparam logic [1:0]  BURST_FIXED4  = 2'h2;

    // additive latency codes
    localparam logic [1:0]  AL_ZERO       = 2'h0;
    localparam logic [1:0]  AL_CL_MINUS1  = 2'h1;
    localparam logic [1:0]  AL_CL_MINUS2  = 2'h2;

    // beats in a burst slot
    localparam logic [2:0]  LAST_BEAT8    = 3'h7;
    localparam logic [2:0]  LAST_BEAT4    = 3'h3;

    typedef enum logic [1:0] {
        RD_IDLE     = 2'b00,
        RD_PREAMBLE = 2'b01,
        RD_DATA     = 2'b10
    } read_state_t;

endpackage : sdram_burst_pkg

`default_nettype wire

/* src/burst_slot_queue.sv */
// burst_slot_queue: in-order queue of accepted column commands
// assumes: one clock, synchronous active-low reset
`default_nettype none

module burst_slot_queue #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic                  head_valid,
    output logic                  full
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] slot_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             do_push;
    logic             do_pop;

    assign full       = (count_reg == (PW+1)'(DEPTH));
    assign head_valid = (count_reg != '0);
    assign head       = slot_reg[rd_ptr_reg];
    assign do_push    = push && !full;
    assign do_pop     = pop && head_valid;

    // storage
    always_ff @(posedge clk) begin
        if (do_push) begin
            slot_reg[wr_ptr_reg] <= push_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            case ({do_push, do_pop})
                2'b10:   count_reg <= count_reg + 1'b1;
                2'b01:   count_reg <= count_reg - 1'b1;
                default: count_reg <= count_reg;
            endcase
        end
    end

endmodule : burst_slot_queue

`default_nettype wire

/* testbench/burst_path_properties.sv */
// checker: read strobe and data pin relations of the burst data path
// assumes: bound into the data path; command clock lasts 8 clk
`default_nettype none
module burst_path_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic dq_oe_n,
    input wire logic data_strobe_out,
    input wire logic data_strobe_c_out,
    input wire logic data_strobe_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_strobe_pair: assert property (
        !data_strobe_oe_n |-> data_strobe_c_out != data_strobe_out) else $error("strobe pair");
    a_data_in_burst: assert property (
        !dq_oe_n |-> !data_strobe_oe_n) else $error("data without strobe");
    a_preamble_quiet: assert property (
        $fell(data_strobe_oe_n) |-> (!data_strobe_out && dq_oe_n) [*7]) else $error("preamble");
    a_data_start_rise: assert property (
        $fell(dq_oe_n) |-> data_strobe_out && !$past(data_strobe_out)) else $error("first beat");
    a_beat_hold: assert property (
        !dq_oe_n && $changed(data_strobe_out) |=> $stable(data_strobe_out) [*3]) else $error("beat");
    a_post_low: assert property (
        $rose(data_strobe_oe_n) |-> !$past(data_strobe_out)) else $error("postamble");
    a_release_data: assert property (
        $rose(dq_oe_n) |-> data_strobe_oe_n) else $error("data release");
    a_burst_len: assert property (
        $fell(data_strobe_oe_n) |-> !data_strobe_oe_n [*8] ##[14:34] data_strobe_oe_n)
        else $error("burst length");
endmodule : burst_path_checker
bind sdram_burst_data_path burst_path_checker u_props (.*);
`default_nettype wire

/* testbench/dram_ctl_model.sv */
// partner: controller driving commands, write strobe and write data
// assumes: the design samples every pin with clk; ck runs free
`default_nettype none
module dram_ctl_model (
    input  wire logic  clk,
    output logic       ck,
    output logic       cmd_activate,
    output logic       cmd_read,
    output logic       cmd_write,
    output logic [2:0] cmd_bank,
    output logic [2:0] cmd_column,
    output logic       cmd_auto_precharge,
    output logic       chop_select_address_bit,
    output logic [7:0] dq_in,
    output logic       write_mask_input,
    output logic       data_strobe_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {cmd_activate, cmd_read, cmd_write, cmd_bank, cmd_column} = '0;
        {cmd_auto_precharge, chop_select_address_bit, dq_in, write_mask_input} = '0;
        data_strobe_in = 1'b1;
        ck = 1'b0;
        #7;
        forever #200 ck = ~ck;
    end
    task automatic issue(input logic [2:0] kind, b, c, input logic ap, chop);
        @(negedge ck);
        @(posedge clk);
        {cmd_activate, cmd_read, cmd_write, cmd_bank, cmd_column} <= {kind, b, c};
        {cmd_auto_precharge, chop_select_address_bit} <= {ap, chop};
        @(posedge ck);
        @(negedge ck);
        @(posedge clk);
        {cmd_activate, cmd_read, cmd_write} <= 3'h0;
    endtask : issue
    task automatic write_seq(input int n, wl, input logic [2:0] b0, b1, c,
            input logic ap, chop, input logic [7:0] base, input logic [15:0] mask);
        fork
            begin
                issue(3'h1, b0, c, ap, chop);
                repeat (3) @(posedge ck);
                if (n > 1) issue(3'h1, b1, c, ap, chop);  // four ck apart
            end
            begin
                @(negedge ck);
                repeat (wl) @(posedge ck);
                @(posedge clk) data_strobe_in <= 1'b1;
                @(negedge ck);
                @(posedge clk) data_strobe_in <= 1'b0;
                for (int k = 0; k < 8 * n; k++) begin
                    repeat (2) @(posedge clk);
                    {dq_in, write_mask_input} <= {base + k[7:0], mask[k]};
                    @(ck);
                    @(posedge clk) data_strobe_in <= ~k[0];
                end
                @(ck);  // low half clock, then released
                @(posedge clk) {dq_in, data_strobe_in} <= ~{dq_in, data_strobe_in};
            end
        join
    endtask : write_seq
endmodule : dram_ctl_model
`default_nettype wire

/* testbench/sdram_burst_data_path_tb.sv */
// testbench: data path against the controller model, expected array kept here
// assumes: write and read latency 5 after reset
`default_nettype none
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module sdram_burst_data_path_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        resetn, reg_wr, reg_rd, ck, cmd_activate, cmd_read, cmd_write, dq_oe_n;
    logic        cmd_auto_precharge, chop_select_address_bit, on_die_termination;
    logic        write_mask_input, data_strobe_in, data_strobe_out, data_strobe_c_out;
    logic        data_strobe_oe_n, termination_on;
    logic [1:0]  mode = 2'h0;
    logic [2:0]  cmd_bank, cmd_column;
    logic [3:0]  reg_addr;
    logic [7:0]  dq_in, dq_out, bank_open;
    logic [7:0]  mem [64];
    logic [15:0] reg_wdata, reg_rdata;
    int          bad_count = 0;
    int          checked = 0;
    always #25 clk = ~clk;
    sdram_burst_data_path dut (.*);
    dram_ctl_model ctl (.*);
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic reg_io(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'b00;
        #1;
    endtask : reg_io
    task automatic set_mode(input logic [15:0] v);
        reg_io(1'b1, sdram_burst_pkg::ADDR_MODE0, v);
        mode = v[1:0];
    endtask : set_mode
    task automatic wait_low(input logic s);
        int w;
        for (w = 0; w < 600 && (s ? data_strobe_oe_n : dq_oe_n) !== 1'b0; w++) @(negedge clk);
        if (w == 600) begin
            bad_count++;
            test_done();
        end
    endtask : wait_low
    task automatic wr(input int n, wl, input logic [2:0] b0, b1, c, input logic ap, chop,
            input logic [7:0] base, input logic [15:0] mask);
        ctl.write_seq(n, wl, b0, b1, c, ap, chop, base, mask);
        for (int j = 0; j < 8 * n; j++)
            if (!mask[j] && !((mode == 2'h2 || (mode == 2'h1 && !chop)) && j % 8 > 3))
                mem[{(j < 8 ? b0 : b1), c + j[2:0]}] = base + j[7:0];
    endtask : wr
    task automatic rd(input logic [2:0] b, c, input logic chop, input int n);
        ctl.issue(3'h2, b, c, 1'b0, chop);  // after the write slot
        wait_low(1'b1);
        `CHECK({data_strobe_out, data_strobe_c_out, dq_oe_n}, 3'b011)
        wait_low(1'b0);
        repeat (2) @(negedge clk);
        for (int k = 0; k < n; k++) begin
            `CHECK({dq_out, data_strobe_out}, {mem[{b, c + k[2:0]}], ~k[0]})
            repeat (4) @(negedge clk);
        end
        `CHECK({data_strobe_oe_n, dq_oe_n}, 2'b11)
    endtask : rd
    task automatic regs_scenario();
        reg_io(1'b0, sdram_burst_pkg::ADDR_MODE0, 16'h0000);
        `CHECK(reg_rdata, 16'h0000)
        reg_io(1'b0, sdram_burst_pkg::ADDR_MODE2, 16'h0000);
        `CHECK(reg_rdata, 16'h0005)
        reg_io(1'b1, sdram_burst_pkg::ADDR_STATUS, 16'hFFFF);
        reg_io(1'b0, sdram_burst_pkg::ADDR_STATUS, 16'h0000);
        `CHECK(reg_rdata, 16'h0000)
        reg_io(1'b0, 4'hF, 16'h0000);
        `CHECK({reg_rdata, termination_on}, 17'h00001)
    endtask : regs_scenario
    task automatic burst_scenario();
        ctl.issue(3'h4, 3'h1, 3'h0, 1'b0, 1'b0);
        ctl.issue(3'h4, 3'h2, 3'h0, 1'b0, 1'b0);
        `CHECK(bank_open, 8'h06)
        wr(2, 5, 3'h1, 3'h2, 3'h0, 1'b0, 1'b0, 8'h10, 16'h0000);
        rd(3'h1, 3'h0, 1'b0, 8);
        rd(3'h2, 3'h0, 1'b1, 8);
        set_mode(16'h0001);
        wr(1, 5, 3'h1, 3'h1, 3'h0, 1'b0, 1'b0, 8'h20, 16'h0002);
        rd(3'h1, 3'h0, 1'b1, 8);
        rd(3'h1, 3'h2, 1'b0, 4);
        set_mode(16'h0002);
        wr(1, 5, 3'h2, 3'h2, 3'h6, 1'b0, 1'b1, 8'h40, 16'h0000);
        rd(3'h2, 3'h6, 1'b1, 4);
    endtask : burst_scenario
    task automatic latency_scenario();
        set_mode(16'h0008);
        wr(1, 9, 3'h1, 3'h1, 3'h3, 1'b1, 1'b1, 8'h50, 16'h0000);
        repeat (8) @(posedge clk);
        `CHECK(bank_open, 8'h04)
        ctl.issue(3'h4, 3'h1, 3'h0, 1'b0, 1'b0);  // after recovery
        rd(3'h1, 3'h0, 1'b0, 8);
        set_mode(16'h0010);
        wr(1, 8, 3'h2, 3'h2, 3'h0, 1'b0, 1'b0, 8'h60, 16'h0081);  // additive code two
        rd(3'h2, 3'h0, 1'b0, 8);
    endtask : latency_scenario
    initial begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, on_die_termination} = '0;
        repeat (6) @(posedge clk);
        {resetn, on_die_termination} <= 2'b11;
        regs_scenario();
        burst_scenario();
        latency_scenario();
        test_done();
    end
endmodule : sdram_burst_data_path_tb
`default_nettype wire
